// [pkg/isc_consts.svh]
`ifndef ISC_CONSTS_SVH
`define ISC_CONSTS_SVH

// Per-cycle state costs with on-chip memory as the target
`define COST_FETCH_MEM 3'h2
`define COST_BRANCH_RD 3'h2
`define COST_STACK 3'h2
`define COST_BYTE_MEM 3'h2
`define COST_WORD_MEM 3'h2
`define COST_INTERNAL 3'h1
// Byte access to a peripheral: fast or slow module
`define COST_BYTE_PERIPH_FAST 3'h2
`define COST_BYTE_PERIPH_SLOW 3'h3

`endif

// [pkg/isc_pkg.sv]
package isc_pkg;

    typedef enum logic [3:0] {
        CLS_REG_ALU,
        CLS_SHORT_BRANCH,
        CLS_BIT_TEST_MEM,
        CLS_BIT_CLEAR_MEM,
        CLS_BIT_SET_MEM,
        CLS_CALL_INDIRECT,
        CLS_OTHER
    } instr_class_t;

    typedef enum logic [2:0] {
        CYC_FETCH,
        CYC_BRANCH_RD,
        CYC_STACK,
        CYC_BYTE,
        CYC_WORD,
        CYC_INTERNAL
    } cycle_kind_t;

    // Cycle counts of each of the six types for one instruction
    typedef struct packed {
        logic [3:0] fetch;
        logic [3:0] branch_rd;
        logic [3:0] stack;
        logic [3:0] byte_acc;
        logic [3:0] word_acc;
        logic [3:0] internal;
    } cycle_counts_t;

    typedef struct packed {
        instr_class_t cls;
        cycle_counts_t other_counts;
        logic periph_target;
        logic periph_slow;
    } instr_req_t;

endpackage

// [src/cycle_count_table.sv]
`timescale 1ns/1ps
`include "isc_consts.svh"

module cycle_count_table (
    input wire isc_pkg::instr_class_t cls,
    input wire isc_pkg::cycle_counts_t other_counts,
    output isc_pkg::cycle_counts_t counts
);
    always_comb begin
        counts = '0;
        case (cls)
            isc_pkg::CLS_REG_ALU: begin
                counts.fetch = 4'h1;
            end
            isc_pkg::CLS_SHORT_BRANCH: begin
                counts.fetch = 4'h2;
            end
            isc_pkg::CLS_BIT_TEST_MEM: begin
                counts.fetch = 4'h2;
                counts.byte_acc = 4'h1;
            end
            isc_pkg::CLS_BIT_CLEAR_MEM: begin
                counts.fetch = 4'h2;
                counts.byte_acc = 4'h2;
            end
            isc_pkg::CLS_BIT_SET_MEM: begin
                counts.fetch = 4'h2;
                counts.byte_acc = 4'h2;
            end
            isc_pkg::CLS_CALL_INDIRECT: begin
                counts.fetch = 4'h2;
                counts.branch_rd = 4'h1;
                counts.stack = 4'h1;
            end
            isc_pkg::CLS_OTHER: begin
                // Table rows outside the covered groups come from the decoder
                counts = other_counts;
            end
            default: begin
                counts = '0;
            end
        endcase
    end
endmodule

// [src/instruction_state_counter.sv]
`timescale 1ns/1ps
`include "isc_consts.svh"

// Contract
// - Duration is the sum over six cycle types of count times state cost.
// - On-chip memory fetch costs two states; internal cycle costs one.
// - Peripheral byte access costs two or three states, by module addressed.
// - Register ops one fetch; short branches two; memory bit test/clear add bytes.
// - Indirect call: two fetches, one branch-address read, one stack cycle.
// - Memory bit set: two fetches, then byte read and byte write.
module instruction_state_counter (
    input wire clk_sys,
    input wire reset_n,
    input wire clk_en,
    input wire start,
    input wire isc_pkg::instr_req_t req,
    output logic ready,
    output logic busy,
    output logic done,
    output logic [7:0] total_states,
    output logic [7:0] elapsed_states,
    output logic [2:0] cycle_kind,
    output logic byte_write
);
    logic rst_meta;
    logic rst_sync_n;
    isc_pkg::cycle_counts_t counts;
    isc_pkg::cycle_counts_t remaining;
    isc_pkg::cycle_counts_t next_remaining;
    isc_pkg::cycle_kind_t kind;
    isc_pkg::cycle_kind_t next_kind;
    logic [2:0] state_left;
    logic [2:0] next_state_left;
    logic [2:0] byte_cost;
    logic next_busy;
    logic next_done;
    logic next_byte_write;
    logic [7:0] next_total;
    logic [7:0] next_elapsed;
    logic [3:0] byte_seen;
    logic [3:0] next_byte_seen;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    cycle_count_table u_table (
        .cls(req.cls),
        .other_counts(req.other_counts),
        .counts(counts)
    );

    // Cost of one cycle of the given kind
    function automatic logic [2:0] cost_of(input isc_pkg::cycle_kind_t k, input logic [2:0] bc);
        case (k)
            isc_pkg::CYC_FETCH: cost_of = `COST_FETCH_MEM;
            isc_pkg::CYC_BRANCH_RD: cost_of = `COST_BRANCH_RD;
            isc_pkg::CYC_STACK: cost_of = `COST_STACK;
            isc_pkg::CYC_BYTE: cost_of = bc;
            isc_pkg::CYC_WORD: cost_of = `COST_WORD_MEM;
            isc_pkg::CYC_INTERNAL: cost_of = `COST_INTERNAL;
            default: cost_of = 3'h1;
        endcase
    endfunction

    // First kind with cycles still pending, in fixed order
    function automatic isc_pkg::cycle_kind_t first_kind(input isc_pkg::cycle_counts_t c);
        if (c.fetch != 4'h0) first_kind = isc_pkg::CYC_FETCH;
        else if (c.branch_rd != 4'h0) first_kind = isc_pkg::CYC_BRANCH_RD;
        else if (c.stack != 4'h0) first_kind = isc_pkg::CYC_STACK;
        else if (c.byte_acc != 4'h0) first_kind = isc_pkg::CYC_BYTE;
        else if (c.word_acc != 4'h0) first_kind = isc_pkg::CYC_WORD;
        else first_kind = isc_pkg::CYC_INTERNAL;
    endfunction

    function automatic logic [7:0] mul(input logic [3:0] n, input logic [2:0] c);
        mul = 8'({4'h0, n} * {5'h0, c});
    endfunction

    logic [2:0] req_byte_cost;
    logic [2:0] next_byte_cost;

    always_comb begin
        req_byte_cost = `COST_BYTE_MEM;
        if (req.periph_target) begin
            req_byte_cost = req.periph_slow ? `COST_BYTE_PERIPH_SLOW
                                            : `COST_BYTE_PERIPH_FAST;
        end
    end

    function automatic isc_pkg::cycle_counts_t dec_kind(input isc_pkg::cycle_counts_t c,
                                                        input isc_pkg::cycle_kind_t k);
        dec_kind = c;
        case (k)
            isc_pkg::CYC_FETCH: dec_kind.fetch = c.fetch - 4'h1;
            isc_pkg::CYC_BRANCH_RD: dec_kind.branch_rd = c.branch_rd - 4'h1;
            isc_pkg::CYC_STACK: dec_kind.stack = c.stack - 4'h1;
            isc_pkg::CYC_BYTE: dec_kind.byte_acc = c.byte_acc - 4'h1;
            isc_pkg::CYC_WORD: dec_kind.word_acc = c.word_acc - 4'h1;
            isc_pkg::CYC_INTERNAL: dec_kind.internal = c.internal - 4'h1;
            default: dec_kind = c;
        endcase
    endfunction

    always_comb begin
        next_remaining = remaining;
        next_kind = kind;
        next_state_left = state_left;
        next_busy = busy;
        next_done = 1'b0;
        next_total = total_states;
        next_elapsed = elapsed_states;
        next_byte_write = byte_write;
        next_byte_seen = byte_seen;
        next_byte_cost = byte_cost;
        if (!busy) begin
            if (start && (counts != '0)) begin
                // Sum of count times cost over all six types
                next_total = mul(counts.fetch, `COST_FETCH_MEM)
                           + mul(counts.branch_rd, `COST_BRANCH_RD)
                           + mul(counts.stack, `COST_STACK)
                           + mul(counts.byte_acc, req_byte_cost)
                           + mul(counts.word_acc, `COST_WORD_MEM)
                           + mul(counts.internal, `COST_INTERNAL);
                next_byte_cost = req_byte_cost;
                next_kind = first_kind(counts);
                next_state_left = cost_of(first_kind(counts), req_byte_cost);
                next_remaining = dec_kind(counts, first_kind(counts));
                next_elapsed = 8'h00;
                next_byte_seen = 4'h0;
                next_byte_write = 1'b0;
                next_busy = 1'b1;
            end
        end else begin
            next_elapsed = elapsed_states + 8'h01;
            if (state_left > 3'h1) begin
                next_state_left = state_left - 3'h1;
            end else if (kind == isc_pkg::CYC_BYTE && byte_write == 1'b0 && byte_seen == 4'h0
                         && remaining.byte_acc != 4'h0) begin
                // Read-modify-write: second byte cycle is the write
                next_byte_seen = 4'h1;
                next_byte_write = 1'b1;
                next_state_left = byte_cost;
                next_remaining = dec_kind(remaining, isc_pkg::CYC_BYTE);
            end else if (remaining != '0) begin
                next_kind = first_kind(remaining);
                next_state_left = cost_of(first_kind(remaining), byte_cost);
                next_remaining = dec_kind(remaining, first_kind(remaining));
                next_byte_write = 1'b0;
            end else begin
                // Last state of last cycle: free for the next fetch
                next_busy = 1'b0;
                next_done = 1'b1;
                next_byte_write = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            remaining <= '0;
            kind <= isc_pkg::CYC_FETCH;
            state_left <= 3'h0;
            busy <= 1'b0;
            done <= 1'b0;
            total_states <= 8'h00;
            elapsed_states <= 8'h00;
            byte_write <= 1'b0;
            byte_seen <= 4'h0;
            byte_cost <= `COST_BYTE_MEM;
            ready <= 1'b0;
        end else if (clk_en) begin
            remaining <= next_remaining;
            kind <= next_kind;
            state_left <= next_state_left;
            busy <= next_busy;
            done <= next_done;
            total_states <= next_total;
            elapsed_states <= next_elapsed;
            byte_write <= next_byte_write;
            byte_seen <= next_byte_seen;
            byte_cost <= next_byte_cost;
            ready <= !next_busy;
        end
    end

    assign cycle_kind = kind;
endmodule

// [verif/isc_props.sv]
`timescale 1ns/1ps
module isc_props (
    input logic clk_sys,
    input logic reset_n,
    input logic clk_en,
    input logic start,
    input isc_pkg::instr_req_t req,
    input logic ready,
    input logic busy,
    input logic done,
    input logic [7:0] total_states,
    input logic [7:0] elapsed_states,
    input logic [2:0] cycle_kind,
    input logic byte_write
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    isc_pkg::cycle_counts_t c;
    logic take;
    logic [7:0] osum;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    assign c = req.other_counts;
    assign take = start && ready && clk_en;
    assign osum = 8'(2 * (c.fetch + c.branch_rd + c.stack + c.byte_acc + c.word_acc)
        + c.internal + (req.periph_target && req.periph_slow ? c.byte_acc : 4'h0));
    // Counts only enabled states, so stalls never shorten the check
    always_comb begin
        next_cnt = busy ? cnt + {7'h00, clk_en} : 8'h00;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 8'h00;
        end else begin
            cnt <= next_cnt;
        end
    end
    AST_REG_ALU: assert property (take && req.cls == isc_pkg::CLS_REG_ALU
        |=> total_states == 8'h02) else $error("register op total");
    AST_BRANCH: assert property (take && req.cls == isc_pkg::CLS_SHORT_BRANCH
        |=> total_states == 8'h04) else $error("branch total");
    AST_PERIPH: assert property (take && req.cls == isc_pkg::CLS_BIT_TEST_MEM
        && req.periph_target |=> total_states == ($past(req.periph_slow) ? 8'h07 : 8'h06))
        else $error("peripheral byte cost");
    AST_CALL: assert property (take && req.cls == isc_pkg::CLS_CALL_INDIRECT
        |=> total_states == 8'h08) else $error("call total");
    AST_SET: assert property (take && req.cls == isc_pkg::CLS_BIT_SET_MEM
        && !req.periph_target |=> total_states == 8'h08) else $error("bit set total");
    AST_RMW_WRITE: assert property (byte_write |-> busy
        && cycle_kind == 3'(isc_pkg::CYC_BYTE)) else $error("write outside byte cycle");
    AST_SUM: assert property (take && req.cls == isc_pkg::CLS_OTHER && (|c)
        |=> total_states == $past(osum)) else $error("generic total");
    AST_DURATION: assert property ($rose(done) |-> cnt == total_states
        && !busy) else $error("states spent differ");
    AST_NO_RESTART: assert property (busy && start |=> $stable(total_states))
        else $error("start taken while busy");
    COV_CALL: cover property (take && req.cls == isc_pkg::CLS_CALL_INDIRECT);
    COV_WRITE: cover property ($rose(byte_write));
    COV_STALL: cover property (busy && !clk_en ##1 busy && clk_en ##1 done);
endmodule
bind instruction_state_counter isc_props u_props (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_en(clk_en), .start(start), .req(req), .ready(ready), .busy(busy), .done(done),
    .total_states(total_states), .elapsed_states(elapsed_states),
    .cycle_kind(cycle_kind), .byte_write(byte_write));

// [verif/far_side_model.sv]
`timescale 1ns/1ps
module far_side_model (
    input logic clk_sys,
    input logic slow,
    output logic clk_en
);
    // A slow module grants every other state only
    logic phase = 1'b0;
    always @(negedge clk_sys) begin
        phase <= slow ? ~phase : 1'b0;
    end
    assign clk_en = ~phase;
endmodule

// [verif/instruction_state_counter_tb_top.sv]
`timescale 1ns/1ps
module instruction_state_counter_tb_top;
    logic clk_sys, reset_n, clk_en, start, slow, ready, busy, done, byte_write;
    isc_pkg::instr_req_t req;
    logic [7:0] total_states, elapsed_states, t, n, e;
    logic [2:0] cycle_kind;
    int err_count = 0;
    int checked = 0;
    int bw = 0;
    far_side_model u_far (.clk_sys(clk_sys), .slow(slow), .clk_en(clk_en));
    instruction_state_counter DUT (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .start(start), .req(req), .ready(ready), .busy(busy), .done(done),
        .total_states(total_states), .elapsed_states(elapsed_states), .cycle_kind(cycle_kind),
        .byte_write(byte_write));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (busy && clk_en && byte_write) bw++;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        if (err_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic run(input isc_pkg::instr_class_t cl, input logic pt, input logic ps,
        input logic [23:0] oc);
        int g;
        g = 0;
        n = 8'h00;
        req = {cl, oc, pt, ps};
        start = 1'b1;
        while (busy !== 1'b1 && g < 50) begin
            @(negedge clk_sys);
            g++;
        end
        start = 1'b0;
        while (done !== 1'b1 && g < 300) begin
            @(posedge clk_sys);
            if (clk_en) n++;
            #1 g++;
        end
        if (g >= 300) err_count++;
        t = total_states;
        e = elapsed_states;
        @(negedge clk_sys);
    endtask
    task automatic t_classes;
        isc_pkg::instr_class_t cl[5] = '{isc_pkg::CLS_REG_ALU, isc_pkg::CLS_SHORT_BRANCH,
            isc_pkg::CLS_BIT_TEST_MEM, isc_pkg::CLS_BIT_CLEAR_MEM, isc_pkg::CLS_CALL_INDIRECT};
        logic [7:0] ex[5] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h08};
        for (int i = 0; i < 5; i++) begin
            run(cl[i], 1'b0, 1'b0, 24'h000000);
            check(t, ex[i]);
            check(n, ex[i]);
            check(e, ex[i]);
        end
    endtask
    task automatic t_periph;
        run(isc_pkg::CLS_BIT_CLEAR_MEM, 1'b1, 1'b0, 24'h000000);
        check(t, 8'h08);
        run(isc_pkg::CLS_BIT_CLEAR_MEM, 1'b1, 1'b1, 24'h000000);
        check(t, 8'h0A);
        run(isc_pkg::CLS_BIT_TEST_MEM, 1'b1, 1'b1, 24'h000000);
        check(n, 8'h07);
    endtask
    task automatic t_set_rmw;
        bw = 0;
        run(isc_pkg::CLS_BIT_SET_MEM, 1'b0, 1'b0, 24'h000000);
        check(t, 8'h08);
        check(8'(bw), 8'h02);
    endtask
    task automatic t_other;
        run(isc_pkg::CLS_OTHER, 1'b0, 1'b0, 24'h100003);
        check(n, 8'h05);
        run(isc_pkg::CLS_OTHER, 1'b1, 1'b1, 24'h111111);
        check(t, 8'h0C);
        req = {isc_pkg::CLS_OTHER, 24'h000000, 1'b0, 1'b0};
        start = 1'b1;
        repeat (4) begin
            @(negedge clk_sys);
            check({7'h00, busy}, 8'h00);
            check(total_states, 8'h0C);
        end
        start = 1'b0;
    endtask
    task automatic t_busy_start;
        req = {isc_pkg::CLS_BIT_SET_MEM, 24'h000000, 1'b0, 1'b0};
        start = 1'b1;
        @(negedge clk_sys);
        // Start held high and a new class offered while busy
        req = {isc_pkg::CLS_SHORT_BRANCH, 24'h000000, 1'b0, 1'b0};
        repeat (8) begin
            check({7'h00, busy}, 8'h01);
            check(total_states, 8'h08);
            @(negedge clk_sys);
        end
        check({7'h00, done}, 8'h01);
        check({7'h00, ready}, 8'h01);
        @(negedge clk_sys);
        start = 1'b0;
        check(total_states, 8'h04);
        repeat (4) @(negedge clk_sys);
        check({7'h00, done}, 8'h01);
    endtask
    task automatic t_stall;
        slow = 1'b1;
        run(isc_pkg::CLS_BIT_CLEAR_MEM, 1'b0, 1'b0, 24'h000000);
        check(n, 8'h08);
        slow = 1'b0;
        @(negedge clk_sys);
    endtask
    initial begin
        #20000;
        err_count++;
        summarize();
    end
    initial begin
        reset_n = 1'b0;
        start = 1'b0;
        slow = 1'b0;
        req = '0;
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
        for (int i = 0; i < 20 && ready !== 1'b1; i++) @(negedge clk_sys);
        t_classes();
        t_periph();
        t_set_rmw();
        t_other();
        t_busy_start();
        t_stall();
        summarize();
    end
endmodule
